// [stack_control_map.svh]
// Purpose: Constants for the control-flow and return-stack executor.
// Assumes: Program counter is a byte address; instructions are 16-bit words.
// Notes: Definitions only.
`ifndef STACK_CONTROL_MAP_SVH
`define STACK_CONTROL_MAP_SVH

// ----------------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------------
`define PC_W 21
`define DATA_W 8
`define STACK_DEPTH 31
`define LEVEL_W 5

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define OPC_NO_OP 16'h0000
`define OPC_PUSH 16'h0005
`define OPC_POP 16'h0006
`define OPC_RESET 16'h00ff
`define OPC_INT_RET_BASE 15'h0008
`define REL_CALL_PREFIX 5'h1b
`define SECOND_WORD_PREFIX 4'hf

// ----------------------------------------------------------------------------
// Phases of the four-phase instruction cycle
// ----------------------------------------------------------------------------
`define Q_DECODE 2'h0
`define Q_PUSH 2'h1
`define Q_POP 2'h2
`define Q_WRITE 2'h3

// ----------------------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------------------
`define PC_RESET 21'h000000
`define PC_STEP 21'h000002
`define W_RESET 8'h00
`define STATUS_RESET 8'h00
`define BANK_RESET 8'h00
`define LEVEL_RESET 5'h00
`define TOP_RESET 21'h000000

`endif

// [stack_control_pkg.sv]
// Purpose: Types shared by the executor and its return stack.
// Assumes: The constant header is on the include path.
// Notes: Types only; numbers live in the header.
`include "stack_control_map.svh"

package stack_control_pkg;

   typedef logic [`PC_W-1:0] addr_t;
   typedef logic [`DATA_W-1:0] byte_t;

   typedef enum logic [2:0] {
      op_idle,
      op_no_operation,
      op_pop,
      op_push,
      op_relative_subroutine_call,
      op_soft_reset,
      op_interrupt_return,
      op_flush
   } op_kind_t;

   typedef enum logic {
      seq_run,
      seq_flush
   } seq_t;

endpackage

// [stack_if.sv]
// Purpose: Carrier between the executor and the return stack.
// Assumes: One push or one pop per clock at most.
// Notes: Top of stack and level come from flip-flops in the stack.
`timescale 1ns/1ps
`include "stack_control_map.svh"

interface stack_if;
   logic push;
   logic pop;
   stack_control_pkg::addr_t push_addr;
   stack_control_pkg::addr_t top_of_stack_entry;
   logic [`LEVEL_W-1:0] level;

   modport ctrl (output push, output pop, output push_addr, input top_of_stack_entry, input level);
   modport store (input push, input pop, input push_addr, output top_of_stack_entry, output level);
endinterface

// [return_stack.sv]
// Purpose: Hardware return stack with a registered top entry.
// Assumes: Caller never pushes and pops in the same clock.
// Notes: A push when full and a pop when empty are ignored.
`timescale 1ns/1ps
`include "stack_control_map.svh"

module return_stack (
   input wire logic ref_clk,
   input wire logic clear,
   stack_if.store stk
);

   stack_control_pkg::addr_t mem [0:`STACK_DEPTH-1];
   stack_control_pkg::addr_t top_ff;
   logic [`LEVEL_W-1:0] level_ff;
   logic full;
   logic empty;

   assign full = (level_ff == `LEVEL_W'(`STACK_DEPTH));
   assign empty = (level_ff == `LEVEL_RESET);
   assign stk.top_of_stack_entry = top_ff;
   assign stk.level = level_ff;

   // ----------------------------------------------------------------------------
   // Entry storage
   // ----------------------------------------------------------------------------
   // The array is not cleared; a reset only empties the level count and zeroes the top entry.
   always_ff @(posedge ref_clk) begin
      if (stk.push && !full) begin
         mem[level_ff] <= stk.push_addr;
      end
   end

   // ----------------------------------------------------------------------------
   // Level and top entry
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (clear) begin
         level_ff <= `LEVEL_RESET;
         top_ff <= `TOP_RESET;
      end else if (stk.push && !full) begin
         level_ff <= level_ff + `LEVEL_W'(1);
         top_ff <= stk.push_addr;
      end else if (stk.pop && !empty) begin
         level_ff <= level_ff - `LEVEL_W'(1);
         if (level_ff > `LEVEL_W'(1)) begin
            top_ff <= mem[level_ff - `LEVEL_W'(2)];
         end else begin
            top_ff <= `TOP_RESET;
         end
      end
   end

endmodule

// [stack_control_instr_exec.sv]
// Purpose: Executes no-op, pop, push, relative call, software reset and interrupt return.
// Assumes: Fetch presents one instruction word, held through phase zero of each cycle.
// Notes: One instruction cycle is four ref_clk periods, phases zero to three.
`timescale 1ns/1ps
`include "stack_control_map.svh"

// Operation
// - Pop discards top entry in one cycle.
// - Previous entry becomes top; PC advances.
// - Push opcode 0x0005, one word, one cycle.
// - Push writes PC plus two as top.
// - Old top moves one level deeper.
// - Relative call: PC becomes PC+2+2n.
// - Call pushes return address; two cycles.
// - Reset opcode 0x00ff clears like master_clear.
// - Interrupt return pops PC, sets enable, restores shadows.
// - Interrupt return opcode 0x001s, two cycles.
// - Shadow bit zero keeps registers unchanged.
module stack_control_instr_exec (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic irq_high_active,
   input wire logic clear_high_enable,
   input wire logic clear_low_enable,
   input wire logic [`DATA_W-1:0] working_shadow,
   input wire logic [`DATA_W-1:0] status_shadow,
   input wire logic [`DATA_W-1:0] bank_select_shadow,
   output logic [1:0] q_phase_ff,
   output logic [`PC_W-1:0] pc_ff,
   output logic [`PC_W-1:0] top_of_stack_entry,
   output logic [`LEVEL_W-1:0] stack_level,
   output logic [`DATA_W-1:0] working_register_ff,
   output logic [`DATA_W-1:0] status_register_ff,
   output logic [`DATA_W-1:0] bank_select_register_ff,
   output logic high_priority_global_enable_ff,
   output logic low_priority_global_enable_ff,
   output logic second_cycle_ff,
   output logic soft_reset_ff
);

   // ----------------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------------
   function automatic stack_control_pkg::op_kind_t decode_op(input logic [15:0] w);
      stack_control_pkg::op_kind_t k;
      k = stack_control_pkg::op_idle;
      if (w == `OPC_NO_OP || w[15:12] == `SECOND_WORD_PREFIX) begin
         k = stack_control_pkg::op_no_operation;
      end else if (w == `OPC_POP) begin
         k = stack_control_pkg::op_pop;
      end else if (w == `OPC_PUSH) begin
         k = stack_control_pkg::op_push;
      end else if (w[15:11] == `REL_CALL_PREFIX) begin
         k = stack_control_pkg::op_relative_subroutine_call;
      end else if (w == `OPC_RESET) begin
         k = stack_control_pkg::op_soft_reset;
      end else if (w[15:1] == `OPC_INT_RET_BASE) begin
         k = stack_control_pkg::op_interrupt_return;
      end else begin
         k = stack_control_pkg::op_no_operation;
      end
      return k;
   endfunction

   stack_control_pkg::op_kind_t op_ff;
   stack_control_pkg::seq_t seq_ff;
   logic [10:0] offset_ff;
   logic shadow_sel_ff;
   logic clear_all;
   logic at_decode;
   logic at_push;
   logic at_pop;
   logic at_write;
   stack_control_pkg::addr_t pc_next_seq;
   stack_control_pkg::addr_t pc_rel_target;
   stack_if stk ();

   // A software reset clears the same state as resetn, one clock after it is started.
   assign clear_all = !resetn || soft_reset_ff;
   assign at_decode = (q_phase_ff == `Q_DECODE);
   assign at_push = (q_phase_ff == `Q_PUSH);
   assign at_pop = (q_phase_ff == `Q_POP);
   assign at_write = (q_phase_ff == `Q_WRITE);
   assign pc_next_seq = pc_ff + `PC_STEP;
   assign pc_rel_target = pc_next_seq + `PC_W'({{(`PC_W-12){offset_ff[10]}}, offset_ff, 1'b0});

   // ----------------------------------------------------------------------------
   // Phase divider
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         q_phase_ff <= `Q_DECODE;
      end else begin
         q_phase_ff <= q_phase_ff + 2'h1;
      end
   end

   // ----------------------------------------------------------------------------
   // Instruction latch and two-cycle sequencing
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         op_ff <= stack_control_pkg::op_idle;
         offset_ff <= 11'h000;
         shadow_sel_ff <= 1'b0;
      end else if (at_decode) begin
         if (seq_ff == stack_control_pkg::seq_flush) begin
            op_ff <= stack_control_pkg::op_flush;
         end else if (instr_valid) begin
            op_ff <= decode_op(instr_word);
            offset_ff <= instr_word[10:0];
            shadow_sel_ff <= instr_word[0];
         end else begin
            op_ff <= stack_control_pkg::op_idle;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         seq_ff <= stack_control_pkg::seq_run;
      end else if (at_write && (op_ff == stack_control_pkg::op_relative_subroutine_call ||
                                op_ff == stack_control_pkg::op_interrupt_return)) begin
         seq_ff <= stack_control_pkg::seq_flush;
      end else if (at_decode) begin
         seq_ff <= stack_control_pkg::seq_run;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         second_cycle_ff <= 1'b0;
      end else if (at_decode) begin
         second_cycle_ff <= (seq_ff == stack_control_pkg::seq_flush);
      end
   end

   // ----------------------------------------------------------------------------
   // Software reset
   // ----------------------------------------------------------------------------
   // Held one clock only; it drops on its own at the next edge, and only resetn resets it, so it cannot latch up.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         soft_reset_ff <= 1'b0;
      end else begin
         soft_reset_ff <= at_push && (op_ff == stack_control_pkg::op_soft_reset);
      end
   end

   // ----------------------------------------------------------------------------
   // Return stack strobes
   // ----------------------------------------------------------------------------
   always_comb begin
      stk.push = 1'b0;
      stk.pop = 1'b0;
      stk.push_addr = pc_next_seq;
      unique case (op_ff)
         stack_control_pkg::op_push: stk.push = at_push && !clear_all;
         stack_control_pkg::op_relative_subroutine_call: stk.push = at_push && !clear_all;
         stack_control_pkg::op_pop: stk.pop = at_pop && !clear_all;
         stack_control_pkg::op_interrupt_return: stk.pop = at_write && !clear_all;
         stack_control_pkg::op_idle,
         stack_control_pkg::op_no_operation,
         stack_control_pkg::op_soft_reset,
         stack_control_pkg::op_flush: begin
         end
      endcase
   end

   return_stack u_stack (
      .ref_clk(ref_clk),
      .clear(clear_all),
      .stk(stk)
   );

   assign top_of_stack_entry = stk.top_of_stack_entry;
   assign stack_level = stk.level;

   // ----------------------------------------------------------------------------
   // Program counter
   // ----------------------------------------------------------------------------
   // The inserted second cycle holds the PC so the target is fetched next.
   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         pc_ff <= `PC_RESET;
      end else if (at_write) begin
         unique case (op_ff)
            stack_control_pkg::op_relative_subroutine_call: pc_ff <= pc_rel_target;
            stack_control_pkg::op_interrupt_return: pc_ff <= stk.top_of_stack_entry;
            stack_control_pkg::op_idle,
            stack_control_pkg::op_flush,
            stack_control_pkg::op_soft_reset: pc_ff <= pc_ff;
            stack_control_pkg::op_no_operation,
            stack_control_pkg::op_pop,
            stack_control_pkg::op_push: pc_ff <= pc_next_seq;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Global interrupt enables
   // ----------------------------------------------------------------------------
   // An enable set by an interrupt return wins over a clear in the same clock.
   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         high_priority_global_enable_ff <= 1'b0;
         low_priority_global_enable_ff <= 1'b0;
      end else begin
         if (at_write && op_ff == stack_control_pkg::op_interrupt_return && irq_high_active) begin
            high_priority_global_enable_ff <= 1'b1;
         end else if (clear_high_enable) begin
            high_priority_global_enable_ff <= 1'b0;
         end
         if (at_write && op_ff == stack_control_pkg::op_interrupt_return && !irq_high_active) begin
            low_priority_global_enable_ff <= 1'b1;
         end else if (clear_low_enable) begin
            low_priority_global_enable_ff <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Shadow restore
   // ----------------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (clear_all) begin
         working_register_ff <= `W_RESET;
         status_register_ff <= `STATUS_RESET;
         bank_select_register_ff <= `BANK_RESET;
      end else if (at_write && op_ff == stack_control_pkg::op_interrupt_return && shadow_sel_ff) begin
         working_register_ff <= working_shadow;
         status_register_ff <= status_shadow;
         bank_select_register_ff <= bank_select_shadow;
      end
      // With the shadow bit clear the three registers simply hold.
   end

endmodule

// [stack_control_props.sv]
// Purpose: Concurrent checks on the executor's ports.
// Assumes: Instruction words are presented for phase zero edges.
// Notes: Bound to every instance of the executor.
`timescale 1ns/1ps
`include "stack_control_map.svh"

module stack_control_props (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic irq_high_active,
   input wire logic [`DATA_W-1:0] working_shadow,
   input wire logic [`DATA_W-1:0] status_shadow,
   input wire logic [`DATA_W-1:0] bank_select_shadow,
   input wire logic [1:0] q_phase_ff,
   input wire logic [`PC_W-1:0] pc_ff,
   input wire logic [`PC_W-1:0] top_of_stack_entry,
   input wire logic [`LEVEL_W-1:0] stack_level,
   input wire logic [`DATA_W-1:0] working_register_ff,
   input wire logic [`DATA_W-1:0] status_register_ff,
   input wire logic [`DATA_W-1:0] bank_select_register_ff,
   input wire logic high_priority_global_enable_ff,
   input wire logic low_priority_global_enable_ff,
   input wire logic second_cycle_ff,
   input wire logic soft_reset_ff
);
   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   // The word at the edge that opens a second cycle is ignored, so it must not count as taken.
   logic pend_ff;
   logic take;
   logic is_call;
   logic is_ret;
   logic [`PC_W-1:0] call_dst;
   assign is_call = instr_word[15:11] == `REL_CALL_PREFIX;
   assign is_ret = instr_word[15:1] == `OPC_INT_RET_BASE;
   assign take = q_phase_ff == 2'h0 && instr_valid && !pend_ff;
   assign call_dst = pc_ff + `PC_STEP + {{9{instr_word[10]}}, instr_word[10:0], 1'b0};
   always_ff @(posedge ref_clk) begin
      if (!resetn || soft_reset_ff) begin
         pend_ff <= 1'b0;
      end else if (q_phase_ff == 2'h0) begin
         pend_ff <= take && (is_call || is_ret);
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   a_phase_steps: assert property (!soft_reset_ff |=> q_phase_ff == $past(q_phase_ff) + 2'h1)
      else $error("phase did not advance by one");
   a_push_entry: assert property (take && (instr_word == `OPC_PUSH || is_call) && stack_level < 5'h1f |->
      ##2 top_of_stack_entry == pc_ff + `PC_STEP && stack_level == $past(stack_level, 2) + 5'h01)
      else $error("push did not place the next address on top");
   a_pop_level: assert property (take && instr_word == `OPC_POP && stack_level != 5'h00 |->
      ##3 stack_level == $past(stack_level, 3) - 5'h01)
      else $error("pop did not drop one level");
   a_seq_pc: assert property (take && (instr_word == `OPC_NO_OP || instr_word == `OPC_PUSH ||
      instr_word == `OPC_POP || instr_word[15:12] == `SECOND_WORD_PREFIX) |->
      ##4 pc_ff == $past(pc_ff, 4) + `PC_STEP && working_register_ff == $past(working_register_ff, 4))
      else $error("sequential step wrong");
   a_call_target: assert property (take && is_call |-> ##4 pc_ff == $past(call_dst, 4))
      else $error("relative call target wrong");
   a_second_hold: assert property (take && (is_call || is_ret) |->
      ##5 (second_cycle_ff && $stable(pc_ff)) [*4] ##1 !second_cycle_ff)
      else $error("second cycle not an idle hold");
   a_ret_pc: assert property (take && is_ret |-> ##4 pc_ff == $past(top_of_stack_entry, 4) &&
      ($past(irq_high_active) ? high_priority_global_enable_ff : low_priority_global_enable_ff))
      else $error("interrupt return pc or enable wrong");
   a_shadow_load: assert property (take && is_ret && instr_word[0] |->
      ##4 working_register_ff == $past(working_shadow) && status_register_ff == $past(status_shadow) &&
      bank_select_register_ff == $past(bank_select_shadow))
      else $error("shadow restore wrong");
   a_shadow_keep: assert property (take && is_ret && !instr_word[0] |->
      ##4 working_register_ff == $past(working_register_ff, 4) && status_register_ff == $past(status_register_ff, 4)
      && bank_select_register_ff == $past(bank_select_register_ff, 4))
      else $error("registers changed without shadow select");
   a_soft_clear: assert property (take && instr_word == `OPC_RESET |-> ##1 !soft_reset_ff ##1 soft_reset_ff
      ##1 (!soft_reset_ff && pc_ff == 21'h000000 && stack_level == 5'h00 && q_phase_ff == 2'h0 &&
      !high_priority_global_enable_ff && !low_priority_global_enable_ff && working_register_ff == 8'h00))
      else $error("software reset did not clear state");

   c_call: cover property (take && is_call);
   c_ret_shadow: cover property (take && is_ret && instr_word[0]);
   c_soft_reset: cover property (soft_reset_ff);
endmodule

bind stack_control_instr_exec stack_control_props i_stack_control_props (.ref_clk(ref_clk), .resetn(resetn),
   .instr_word(instr_word), .instr_valid(instr_valid), .irq_high_active(irq_high_active),
   .working_shadow(working_shadow), .status_shadow(status_shadow), .bank_select_shadow(bank_select_shadow),
   .q_phase_ff(q_phase_ff), .pc_ff(pc_ff), .top_of_stack_entry(top_of_stack_entry), .stack_level(stack_level),
   .working_register_ff(working_register_ff), .status_register_ff(status_register_ff),
   .bank_select_register_ff(bank_select_register_ff),
   .high_priority_global_enable_ff(high_priority_global_enable_ff),
   .low_priority_global_enable_ff(low_priority_global_enable_ff), .second_cycle_ff(second_cycle_ff),
   .soft_reset_ff(soft_reset_ff));

// [fetch_model.sv]
// Purpose: Behavioural fetch unit feeding instruction words.
// Assumes: The bench raises a request only at a phase zero boundary.
// Notes: Outside phase zero the word toggles so stale values never look valid.
`timescale 1ns/1ps

module fetch_model (
   input wire logic ref_clk,
   input wire logic [1:0] q_phase_ff,
   input wire logic [15:0] req_word,
   input wire logic req_valid,
   output logic [15:0] instr_word,
   output logic instr_valid
);
   initial begin
      instr_word = 16'h0000;
      instr_valid = 1'b0;
   end
   always @(posedge ref_clk) begin
      #2;
      if (q_phase_ff == 2'h0 && req_valid) begin
         instr_word = req_word;
         instr_valid = 1'b1;
      end else begin
         instr_word = ~instr_word;
         instr_valid = 1'b0;
      end
   end
endmodule

// [stack_control_instr_exec_bench.sv]
// Purpose: Self-checking bench for the control-flow executor.
// Assumes: The bench keeps its own copy of the return stack.
// Notes: Every instruction starts at a phase zero boundary.
`timescale 1ns/1ps
`include "stack_control_map.svh"

module stack_control_instr_exec_bench;
   // ----------------------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] req_word = 16'h0000;
   logic req_valid = 1'b0;
   logic irq_high_active = 1'b0;
   logic clear_high_enable = 1'b0;
   logic clear_low_enable = 1'b0;
   logic [7:0] sh_w = 8'h00;
   logic [7:0] sh_s = 8'h00;
   logic [7:0] sh_b = 8'h00;
   logic [15:0] instr_word;
   logic instr_valid;
   logic [1:0] q_phase_ff;
   stack_control_pkg::addr_t pc_ff;
   stack_control_pkg::addr_t top_of_stack_entry;
   logic [4:0] stack_level;
   logic [7:0] working_register_ff;
   logic [7:0] status_register_ff;
   logic [7:0] bank_select_register_ff;
   logic high_priority_global_enable_ff;
   logic low_priority_global_enable_ff;
   logic second_cycle_ff;
   logic soft_reset_ff;
   int failures = 0;
   int tests_run = 0;
   int seed = 32'hde14;
   stack_control_pkg::addr_t exp_pc = 21'h000000;
   stack_control_pkg::addr_t exp_stk[$];
   logic [7:0] exp_w = 8'h00;
   logic [7:0] exp_s = 8'h00;
   logic [7:0] exp_b = 8'h00;
   logic exp_hi = 1'b0;
   logic exp_lo = 1'b0;

   fetch_model i_fetch_model (.ref_clk(ref_clk), .q_phase_ff(q_phase_ff), .req_word(req_word),
      .req_valid(req_valid), .instr_word(instr_word), .instr_valid(instr_valid));
   stack_control_instr_exec i_stack_control_instr_exec (.ref_clk(ref_clk), .resetn(resetn),
      .instr_word(instr_word), .instr_valid(instr_valid), .irq_high_active(irq_high_active),
      .clear_high_enable(clear_high_enable), .clear_low_enable(clear_low_enable), .working_shadow(sh_w),
      .status_shadow(sh_s), .bank_select_shadow(sh_b), .q_phase_ff(q_phase_ff), .pc_ff(pc_ff),
      .top_of_stack_entry(top_of_stack_entry), .stack_level(stack_level),
      .working_register_ff(working_register_ff), .status_register_ff(status_register_ff),
      .bank_select_register_ff(bank_select_register_ff),
      .high_priority_global_enable_ff(high_priority_global_enable_ff),
      .low_priority_global_enable_ff(low_priority_global_enable_ff), .second_cycle_ff(second_cycle_ff),
      .soft_reset_ff(soft_reset_ff));

   // ----------------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------------
   task automatic results();
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_addr(input logic [20:0] got, input logic [20:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic stack_control_pkg::addr_t call_pc(input stack_control_pkg::addr_t pc, input logic [15:0] w);
      return pc + 21'h000002 + {{9{w[10]}}, w[10:0], 1'b0};
   endfunction
   // The request drops after the taking edge, so the second cycle never sees a valid word.
   task automatic issue(input logic [15:0] w, input int edges);
      req_word = w;
      req_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      req_valid = 1'b0;
      repeat (edges - 1) @(posedge ref_clk);
      #1;
   endtask
   task automatic check_all();
      chk_addr(pc_ff, exp_pc);
      chk_addr(top_of_stack_entry, exp_stk.size() > 0 ? exp_stk[0] : 21'h000000);
      chk_byte({3'h0, stack_level}, 8'(exp_stk.size()));
      chk_byte(working_register_ff, exp_w);
      chk_byte(status_register_ff, exp_s);
      chk_byte(bank_select_register_ff, exp_b);
      chk_byte({7'h00, high_priority_global_enable_ff}, {7'h00, exp_hi});
      chk_byte({7'h00, low_priority_global_enable_ff}, {7'h00, exp_lo});
   endtask
   task automatic do_op(input int k, input logic [31:0] v);
      logic [15:0] w;
      w = {`REL_CALL_PREFIX, v[10:0]};
      if ((k == 0 || k == 2) && exp_stk.size() < 31) exp_stk.push_front(exp_pc + 21'h000002);
      if (k == 3) exp_pc = exp_stk.size() > 0 ? exp_stk[0] : 21'h000000;
      if ((k == 1 || k == 3) && exp_stk.size() > 0) void'(exp_stk.pop_front());
      if (k == 2) exp_pc = call_pc(exp_pc, w);
      if (k != 2 && k != 3) exp_pc = exp_pc + 21'h000002;
      if (k == 3) begin
         irq_high_active = v[1];
         sh_w = v[15:8];
         sh_s = v[23:16];
         sh_b = v[31:24];
         if (v[1]) exp_hi = 1'b1;
         else exp_lo = 1'b1;
         if (v[0]) begin
            exp_w = sh_w;
            exp_s = sh_s;
            exp_b = sh_b;
         end
      end
      case (k)
         0: issue(`OPC_PUSH, 4);
         1: issue(`OPC_POP, 4);
         2: issue(w, 8);
         3: issue({`OPC_INT_RET_BASE, v[0]}, 8);
         default: issue(v[2] ? {`SECOND_WORD_PREFIX, v[15:4]} : `OPC_NO_OP, 4);
      endcase
      check_all();
   endtask

   // ----------------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------------
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      failures++;
      results();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      check_all();
      for (int i = 0; i < 32; i++) do_op(0, 32'h0);
      for (int i = 0; i < 33; i++) do_op(1, 32'h0);
      do_op(2, 32'h400);
      do_op(2, 32'h3ff);
      do_op(3, 32'h5aa53c03);
      do_op(3, 32'h12345600);
      clear_high_enable = 1'b1;
      clear_low_enable = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      clear_high_enable = 1'b0;
      clear_low_enable = 1'b0;
      exp_hi = 1'b0;
      exp_lo = 1'b0;
      check_all();
      for (int i = 0; i < 80; i++) do_op(($random(seed) & 32'h7) % 5, $random(seed));
      do_op(3, 32'hffffffff);
      // The clear lands at the third edge: take, start pulse, then the clearing edge.
      issue(`OPC_RESET, 3);
      exp_pc = 21'h000000;
      exp_stk.delete();
      exp_w = 8'h00;
      exp_s = 8'h00;
      exp_b = 8'h00;
      exp_hi = 1'b0;
      exp_lo = 1'b0;
      check_all();
      chk_byte({6'h00, q_phase_ff}, 8'h00);
      do_op(0, 32'h0);
      results();
   end
endmodule
